// file: cstr_consts.svh
// Constants for the CPU status and trap save register file
`ifndef CSTR_CONSTS_SVH
`define CSTR_CONSTS_SVH

// System register numbers used by the load/store system register instructions
`define CSTR_SR_NUM_W 5
`define CSTR_SR_PSW 5'h05
`define CSTR_SR_TABLE_CALL_SAVED_PC 5'h10
`define CSTR_SR_TABLE_CALL_SAVED_STATUS 5'h11
`define CSTR_SR_TRAP_SAVED_PC 5'h12
`define CSTR_SR_TRAP_SAVED_STATUS 5'h13
`define CSTR_SR_TABLE_CALL_BASE 5'h14
`define CSTR_SR_PROGRAM_IDENTIFIER 5'h17

// Status word flag positions
`define CSTR_PSW_NP 7
`define CSTR_PSW_EP 6
`define CSTR_PSW_ID 5
`define CSTR_PSW_SAT 4
`define CSTR_PSW_CY 3
`define CSTR_PSW_OV 2
`define CSTR_PSW_S 1
`define CSTR_PSW_Z 0

// Implemented widths; bits above read as zero
`define CSTR_PSW_W 8
`define CSTR_PC_W 26
`define CSTR_ID_W 8

// Reset values
`define CSTR_PSW_RST 8'h20
`define CSTR_PC_RST 26'h0000000
`define CSTR_ID_RST 8'h00
`define CSTR_WORD_ZERO 32'h0000_0000

// Saturation clamp values
`define CSTR_SAT_POS_MAX 32'h7FFF_FFFF
`define CSTR_SAT_NEG_MAX 32'h8000_0000

// Edges spent in the mode pin synchroniser before the pins are trusted
`define CSTR_SYNC_EDGES 2'h2
`define CSTR_CNT_ONE 2'h1
`define CSTR_CNT_ZERO 2'h0

`endif

// file: cstr_core_model.sv
// Behavioural execution core: register loads and stores, result flags, trap events
`include "cstr_consts.svh"
module cstr_core_model (
    input wire logic clk_i,
    output cstr_pkg::cstr_sr_req_t sr_req_o,
    output cstr_pkg::cstr_flags_t flags_o,
    output logic [5:0] ev_o,
    output logic [25:0] next_pc_o,
    input wire logic [31:0] rdata_i,
    input wire logic denied_i
);
    import cstr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sr_req_o = '0;
        flags_o = '0;
        ev_o = '0;
        next_pc_o = '0;
    end
    // Released fields show the inverse so stale data is never mistaken for live data
    task automatic sr_access(input logic wr, input logic rd, input logic [4:0] num,
                             input logic [31:0] wd, output logic [31:0] rd_o, output logic dn);
        @(posedge clk_i);
        sr_req_o <= '{wr: wr, rd: rd, num: num, wdata: wd};
        @(posedge clk_i);
        sr_req_o <= '{wr: 1'b0, rd: 1'b0, num: ~num, wdata: ~wd};
        @(posedge clk_i);
        rd_o = rdata_i;
        dn = denied_i;
    endtask : sr_access
    task automatic exec(input cstr_flags_t f);
        @(posedge clk_i);
        flags_o <= f;
        @(posedge clk_i);
        flags_o <= {1'b0, ~f[36:0]};
        @(posedge clk_i);
    endtask : exec
    task automatic event_pulse(input int idx, input logic [25:0] pc);
        @(posedge clk_i);
        ev_o[idx] <= 1'b1;
        next_pc_o <= pc;
        @(posedge clk_i);
        ev_o <= '0;
        next_pc_o <= ~pc;
    endtask : event_pulse
    task automatic init_id(output logic [31:0] rd_o, output logic dn);
        sr_access(1'b1, 1'b0, `CSTR_SR_PROGRAM_IDENTIFIER, 32'h0000_0000, rd_o, dn);
    endtask : init_id
endmodule : cstr_core_model

// file: cstr_pkg.sv
// Types for the CPU status and trap save register file
`include "cstr_consts.svh"

package cstr_pkg;

    typedef enum logic [1:0] {
        BOOT_RESET,
        BOOT_SYNC,
        BOOT_RUN
    } cstr_boot_t;

    // Result flags from the execution stage, one instruction per valid cycle
    typedef struct packed {
        logic valid;
        logic sat_op;
        logic cy;
        logic ov;
        logic s;
        logic z;
        logic [31:0] result;
    } cstr_flags_t;

    // System register load (wr) or store (rd) request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`CSTR_SR_NUM_W-1:0] num;
        logic [31:0] wdata;
    } cstr_sr_req_t;

    typedef struct packed {
        logic [`CSTR_PSW_W-1:0] program_status_word;
        logic [`CSTR_PC_W-1:0] table_call_saved_pc;
        logic [`CSTR_PSW_W-1:0] table_call_saved_status;
        logic [`CSTR_PC_W-1:0] trap_saved_pc;
        logic [`CSTR_PSW_W-1:0] trap_saved_status;
        logic [`CSTR_PC_W-1:1] table_call_base;
        logic [`CSTR_ID_W-1:0] program_identifier;
        logic trap_open;
        logic [31:0] rdata;
        logic rvalid;
        logic denied;
        logic [`CSTR_PC_W-1:0] restore_pc;
        logic restore_valid;
        logic [31:0] sat_result;
        logic sat_valid;
        logic [1:0] mode_meta;
        logic [1:0] mode_sync;
        logic single_chip;
        logic port_mode;
        logic fetch_start;
        cstr_boot_t boot;
        logic [1:0] boot_cnt;
    } cstr_state_t;

endpackage : cstr_pkg

// file: cstr_regs.sv
// CPU status word, table-call and trap save registers, boot mode sequencing
`include "cstr_consts.svh"

module cstr_regs #(
    parameter logic [`CSTR_PC_W-1:0] RESET_ENTRY = `CSTR_PC_RST
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire cstr_pkg::cstr_sr_req_t SR_REQ_I,
    output logic [31:0] SR_RDATA_O,
    output logic SR_RVALID_O,
    output logic SR_DENIED_O,
    input wire cstr_pkg::cstr_flags_t FLAGS_I,
    output logic [31:0] SAT_RESULT_O,
    output logic SAT_VALID_O,
    input wire logic TABLE_CALL_I,
    input wire logic EXC_TRAP_I,
    input wire logic DEBUG_TRAP_I,
    input wire logic ILLEGAL_OP_I,
    input wire logic DEBUG_RET_I,
    input wire logic EXCEPTION_I,
    input wire logic [`CSTR_PC_W-1:0] NEXT_PC_I,
    output logic [`CSTR_PC_W-1:0] RESTORE_PC_O,
    output logic RESTORE_VALID_O,
    input wire logic NMI_REQ_I,
    output logic NMI_ACK_O,
    input wire logic IRQ_REQ_I,
    output logic IRQ_ACK_O,
    output logic [31:0] PSW_O,
    output logic [31:0] TABLE_BASE_O,
    output logic [31:0] PROGRAM_ID_O,
    output logic TRAP_OPEN_O,
    input wire logic MODE_SELECT_LOW_PIN_I,
    input wire logic MODE_SELECT_HIGH_PIN_I,
    output logic SINGLE_CHIP_O,
    output logic PORT_MODE_O,
    output logic FETCH_START_O,
    output logic [`CSTR_PC_W-1:0] FETCH_ADDR_O
);
    import cstr_pkg::*;

    // The program counter never holds an odd address
    if (RESET_ENTRY[0] != 1'b0) begin : g_entry_check
        $error("RESET_ENTRY must be an even address");
    end

    cstr_state_t state_reg;
    cstr_state_t state_next;
    logic psw_load;
    logic trap_hit;

    // A status word load in this cycle holds off every acknowledge
    assign psw_load = SR_REQ_I.wr && (SR_REQ_I.num == `CSTR_SR_PSW);
    assign trap_hit = EXC_TRAP_I || DEBUG_TRAP_I || ILLEGAL_OP_I;

    // EP deliberately does not appear here: exception handlers stay interruptible
    assign NMI_ACK_O = NMI_REQ_I && !state_reg.program_status_word[`CSTR_PSW_NP] && !psw_load;
    assign IRQ_ACK_O = IRQ_REQ_I && !state_reg.program_status_word[`CSTR_PSW_NP]
        && !state_reg.program_status_word[`CSTR_PSW_ID] && !psw_load;

    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.denied = 1'b0;
        state_next.restore_valid = 1'b0;
        state_next.sat_valid = 1'b0;
        state_next.fetch_start = 1'b0;

        // Mode pins come from outside: two flops before any logic looks
        state_next.mode_meta = {MODE_SELECT_HIGH_PIN_I, MODE_SELECT_LOW_PIN_I};
        state_next.mode_sync = state_reg.mode_meta;

        case (state_reg.boot)
            BOOT_RESET: begin
                state_next.port_mode = 1'b1;
                state_next.boot_cnt = `CSTR_SYNC_EDGES;
                state_next.boot = BOOT_SYNC;
            end
            BOOT_SYNC: begin
                if (state_reg.boot_cnt == `CSTR_CNT_ZERO) begin
                    // Pins are latched once; later changes are not followed
                    state_next.single_chip = (state_reg.mode_sync == 2'h0);
                    state_next.fetch_start = (state_reg.mode_sync == 2'h0);
                    state_next.boot = BOOT_RUN;
                end else begin
                    state_next.boot_cnt = state_reg.boot_cnt - `CSTR_CNT_ONE;
                end
            end
            BOOT_RUN: begin
                state_next.boot = BOOT_RUN;
            end
            default: begin
                state_next.boot = BOOT_RESET;
            end
        endcase

        // Execution result flags
        if (FLAGS_I.valid) begin
            state_next.program_status_word[`CSTR_PSW_CY] = FLAGS_I.cy;
            state_next.program_status_word[`CSTR_PSW_OV] = FLAGS_I.ov;
            state_next.program_status_word[`CSTR_PSW_S] = FLAGS_I.s;
            state_next.program_status_word[`CSTR_PSW_Z] = FLAGS_I.z;
            if (FLAGS_I.sat_op) begin
                state_next.sat_valid = 1'b1;
                if (FLAGS_I.ov) begin
                    state_next.program_status_word[`CSTR_PSW_SAT] = 1'b1;
                    state_next.program_status_word[`CSTR_PSW_Z] = 1'b0;
                    // The core reports the true sign, so it picks the clamp side
                    state_next.sat_result = FLAGS_I.s ? `CSTR_SAT_NEG_MAX
                        : `CSTR_SAT_POS_MAX;
                end else begin
                    state_next.sat_result = FLAGS_I.result;
                end
            end
            // Non-saturating instructions leave the sticky flag alone
        end

        if (NMI_ACK_O) begin
            state_next.program_status_word[`CSTR_PSW_NP] = 1'b1;
        end
        if (EXCEPTION_I) begin
            state_next.program_status_word[`CSTR_PSW_EP] = 1'b1;
        end

        // Save registers take the status word as it stood before this cycle
        if (TABLE_CALL_I) begin
            state_next.table_call_saved_pc = NEXT_PC_I;
            state_next.table_call_saved_status = state_reg.program_status_word;
        end
        if (trap_hit) begin
            state_next.trap_saved_pc = NEXT_PC_I;
            state_next.trap_saved_status = state_reg.program_status_word;
        end
        if (DEBUG_TRAP_I || ILLEGAL_OP_I) begin
            state_next.trap_open = 1'b1;
        end

        // System register load; narrow fields drop the reserved bits
        if (SR_REQ_I.wr) begin
            case (SR_REQ_I.num)
                `CSTR_SR_PSW: begin
                    state_next.program_status_word = SR_REQ_I.wdata[`CSTR_PSW_W-1:0];
                end
                `CSTR_SR_TABLE_CALL_SAVED_PC: begin
                    state_next.table_call_saved_pc = SR_REQ_I.wdata[`CSTR_PC_W-1:0];
                end
                `CSTR_SR_TABLE_CALL_SAVED_STATUS: begin
                    state_next.table_call_saved_status = SR_REQ_I.wdata[`CSTR_PSW_W-1:0];
                end
                `CSTR_SR_TRAP_SAVED_PC: begin
                    if (state_reg.trap_open) begin
                        state_next.trap_saved_pc = SR_REQ_I.wdata[`CSTR_PC_W-1:0];
                    end else begin
                        state_next.denied = 1'b1;
                    end
                end
                `CSTR_SR_TRAP_SAVED_STATUS: begin
                    if (state_reg.trap_open) begin
                        state_next.trap_saved_status = SR_REQ_I.wdata[`CSTR_PSW_W-1:0];
                    end else begin
                        state_next.denied = 1'b1;
                    end
                end
                `CSTR_SR_TABLE_CALL_BASE: begin
                    state_next.table_call_base = SR_REQ_I.wdata[`CSTR_PC_W-1:1];
                end
                `CSTR_SR_PROGRAM_IDENTIFIER: begin
                    state_next.program_identifier = SR_REQ_I.wdata[`CSTR_ID_W-1:0];
                end
                default: begin
                    state_next.denied = 1'b1;
                end
            endcase
        end

        // System register store: answer one cycle later
        if (SR_REQ_I.rd) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = `CSTR_WORD_ZERO;
            case (SR_REQ_I.num)
                `CSTR_SR_PSW: begin
                    state_next.rdata[`CSTR_PSW_W-1:0] = state_reg.program_status_word;
                end
                `CSTR_SR_TABLE_CALL_SAVED_PC: begin
                    state_next.rdata[`CSTR_PC_W-1:0] = state_reg.table_call_saved_pc;
                end
                `CSTR_SR_TABLE_CALL_SAVED_STATUS: begin
                    state_next.rdata[`CSTR_PSW_W-1:0] = state_reg.table_call_saved_status;
                end
                `CSTR_SR_TRAP_SAVED_PC: begin
                    if (state_reg.trap_open) begin
                        state_next.rdata[`CSTR_PC_W-1:0] = state_reg.trap_saved_pc;
                    end else begin
                        state_next.denied = 1'b1;
                    end
                end
                `CSTR_SR_TRAP_SAVED_STATUS: begin
                    if (state_reg.trap_open) begin
                        state_next.rdata[`CSTR_PSW_W-1:0] = state_reg.trap_saved_status;
                    end else begin
                        state_next.denied = 1'b1;
                    end
                end
                `CSTR_SR_TABLE_CALL_BASE: begin
                    state_next.rdata[`CSTR_PC_W-1:1] = state_reg.table_call_base;
                end
                `CSTR_SR_PROGRAM_IDENTIFIER: begin
                    state_next.rdata[`CSTR_ID_W-1:0] = state_reg.program_identifier;
                end
                default: begin
                    state_next.denied = 1'b1;
                end
            endcase
        end

        // Debug return wins over every other status word source this cycle
        if (DEBUG_RET_I) begin
            state_next.program_status_word = state_reg.trap_saved_status;
            state_next.restore_pc = state_reg.trap_saved_pc;
            state_next.restore_valid = 1'b1;
            state_next.trap_open = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_reg.program_status_word <= `CSTR_PSW_RST;
            state_reg.table_call_saved_pc <= `CSTR_PC_RST;
            state_reg.table_call_saved_status <= `CSTR_ID_RST;
            state_reg.trap_saved_pc <= `CSTR_PC_RST;
            state_reg.trap_saved_status <= `CSTR_ID_RST;
            state_reg.table_call_base <= (`CSTR_PC_W-1)'(`CSTR_PC_RST >> 1);
            state_reg.program_identifier <= `CSTR_ID_RST;
            state_reg.trap_open <= 1'b0;
            state_reg.rdata <= `CSTR_WORD_ZERO;
            state_reg.rvalid <= 1'b0;
            state_reg.denied <= 1'b0;
            state_reg.restore_pc <= `CSTR_PC_RST;
            state_reg.restore_valid <= 1'b0;
            state_reg.sat_result <= `CSTR_WORD_ZERO;
            state_reg.sat_valid <= 1'b0;
            state_reg.mode_meta <= 2'h0;
            state_reg.mode_sync <= 2'h0;
            state_reg.single_chip <= 1'b0;
            state_reg.port_mode <= 1'b1;
            state_reg.fetch_start <= 1'b0;
            state_reg.boot <= BOOT_RESET;
            state_reg.boot_cnt <= `CSTR_CNT_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign SR_RDATA_O = state_reg.rdata;
    assign SR_RVALID_O = state_reg.rvalid;
    assign SR_DENIED_O = state_reg.denied;
    assign SAT_RESULT_O = state_reg.sat_result;
    assign SAT_VALID_O = state_reg.sat_valid;
    assign RESTORE_PC_O = state_reg.restore_pc;
    assign RESTORE_VALID_O = state_reg.restore_valid;
    assign PSW_O = {24'h000000, state_reg.program_status_word};
    assign TABLE_BASE_O = {6'h00, state_reg.table_call_base, 1'b0};
    assign PROGRAM_ID_O = {24'h000000, state_reg.program_identifier};
    assign TRAP_OPEN_O = state_reg.trap_open;
    assign SINGLE_CHIP_O = state_reg.single_chip;
    // Bus pins stay ports until software reprograms them elsewhere
    assign PORT_MODE_O = state_reg.port_mode;
    assign FETCH_START_O = state_reg.fetch_start;
    assign FETCH_ADDR_O = RESET_ENTRY;

endmodule : cstr_regs

// file: cstr_regs_asserts.sv
// Port checker for the status word and trap save register file
`include "cstr_consts.svh"
module cstr_regs_asserts (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire cstr_pkg::cstr_sr_req_t SR_REQ_I,
    input wire cstr_pkg::cstr_flags_t FLAGS_I,
    input wire logic DEBUG_RET_I,
    input wire logic IRQ_REQ_I,
    input wire logic IRQ_ACK_O,
    input wire logic NMI_ACK_O,
    input wire logic [31:0] PSW_O,
    input wire logic [31:0] SAT_RESULT_O,
    input wire logic SAT_VALID_O,
    input wire logic RESTORE_VALID_O,
    input wire logic TRAP_OPEN_O,
    input wire logic SR_DENIED_O
);
    import cstr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ld;
    logic quiet;
    logic clamp_sticky_flag;
    assign ld = SR_REQ_I.wr && (SR_REQ_I.num == `CSTR_SR_PSW);
    assign quiet = !ld && !DEBUG_RET_I;
    assign clamp_sticky_flag = FLAGS_I.valid && FLAGS_I.sat_op && quiet;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_load;
        ld && !DEBUG_RET_I |=> PSW_O == {24'h000000, $past(SR_REQ_I.wdata[7:0])};
    endproperty
    a_load: assert property (p_load) else $error("status load not applied");
    property p_hold;
        ld |-> !IRQ_ACK_O && !NMI_ACK_O;
    endproperty
    a_hold: assert property (p_hold) else $error("ack during status load");
    property p_np_set;
        NMI_ACK_O && quiet |=> PSW_O[`CSTR_PSW_NP];
    endproperty
    a_np_set: assert property (p_np_set) else $error("nmi flag not set");
    property p_np_block;
        PSW_O[`CSTR_PSW_NP] |-> !IRQ_ACK_O && !NMI_ACK_O;
    endproperty
    a_np_block: assert property (p_np_block) else $error("ack while nmi active");
    property p_irq_ok;
        IRQ_REQ_I && !ld && PSW_O[7:5] != 3'h1 && !PSW_O[7] && !PSW_O[5] |-> IRQ_ACK_O;
    endproperty
    a_irq_ok: assert property (p_irq_ok) else $error("enabled irq not acked");
    property p_irq_mask;
        PSW_O[`CSTR_PSW_ID] |-> !IRQ_ACK_O;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq acked");
    property p_clamp;
        clamp_sticky_flag && FLAGS_I.ov |=> SAT_VALID_O && PSW_O[4] && PSW_O[2]
            && SAT_RESULT_O == ($past(FLAGS_I.s) ? `CSTR_SAT_NEG_MAX : `CSTR_SAT_POS_MAX);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp wrong");
    property p_pass;
        clamp_sticky_flag && !FLAGS_I.ov |=> SAT_RESULT_O == $past(FLAGS_I.result) && !PSW_O[2]
            && $stable(PSW_O[4]);
    endproperty
    a_pass: assert property (p_pass) else $error("in-range result wrong");
    property p_sticky;
        FLAGS_I.valid && !FLAGS_I.sat_op && quiet |=> $stable(PSW_O[4]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("sat flag moved");
    property p_flags;
        FLAGS_I.valid && !FLAGS_I.sat_op && quiet
            |=> PSW_O[3:0] == $past({FLAGS_I.cy, FLAGS_I.ov, FLAGS_I.s, FLAGS_I.z});
    endproperty
    a_flags: assert property (p_flags) else $error("result flags wrong");
    property p_ret;
        DEBUG_RET_I |=> RESTORE_VALID_O && !TRAP_OPEN_O;
    endproperty
    a_ret: assert property (p_ret) else $error("debug return wrong");
    property p_window;
        (SR_REQ_I.wr || SR_REQ_I.rd) && !TRAP_OPEN_O
            && (SR_REQ_I.num == `CSTR_SR_TRAP_SAVED_PC || SR_REQ_I.num == `CSTR_SR_TRAP_SAVED_STATUS) |=> SR_DENIED_O;
    endproperty
    a_window: assert property (p_window) else $error("closed trap reg reached");
    property p_rsvd;
        PSW_O[31:8] == 24'h000000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
    c_clamp: cover property (clamp_sticky_flag && FLAGS_I.ov);
    c_denied: cover property (SR_DENIED_O);
    c_ret: cover property (RESTORE_VALID_O);
    c_irq_ep: cover property (IRQ_ACK_O && PSW_O[6]);
endmodule : cstr_regs_asserts

bind cstr_regs cstr_regs_asserts i_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .SR_REQ_I(SR_REQ_I), .FLAGS_I(FLAGS_I), .DEBUG_RET_I(DEBUG_RET_I), .IRQ_REQ_I(IRQ_REQ_I),
    .IRQ_ACK_O(IRQ_ACK_O), .NMI_ACK_O(NMI_ACK_O), .PSW_O(PSW_O), .SAT_RESULT_O(SAT_RESULT_O),
    .SAT_VALID_O(SAT_VALID_O), .RESTORE_VALID_O(RESTORE_VALID_O), .TRAP_OPEN_O(TRAP_OPEN_O),
    .SR_DENIED_O(SR_DENIED_O));

// file: tb.sv
// Self-checking testbench for the status word and trap save register file
`include "cstr_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cstr_pkg::*;
    typedef struct packed {
        logic sat_op;
        logic cy;
        logic ov;
        logic s;
        logic z;
        logic [31:0] result;
        logic [4:0] psw_low;
        logic [31:0] sat_res;
    } cstr_row_t;
    localparam logic [25:0] ENTRY = 26'h0000100;
    localparam cstr_row_t ROWS [6] = '{'{0, 1, 0, 0, 1, 32'h0, 5'h09, 32'h0},
        '{1, 0, 0, 1, 0, 32'hFFFF_FFF0, 5'h02, 32'hFFFF_FFF0},
        '{1, 0, 1, 0, 0, 32'h1, 5'h14, 32'h7FFF_FFFF}, '{1, 0, 0, 0, 0, 32'h5, 5'h10, 32'h5},
        '{0, 0, 1, 1, 0, 32'h0, 5'h16, 32'h0}, '{1, 1, 1, 1, 0, 32'h0, 5'h1E, 32'h8000_0000}};
    localparam logic [4:0] NUMS [5] = '{5'h10, 5'h11, 5'h14, 5'h17, 5'h06};
    localparam logic [31:0] MASKS [5] = '{32'h03FF_FFFF, 32'hFF, 32'h03FF_FFFE, 32'hFF, 32'h0};
    logic clk, rst_n, irq_req, nmi_req, dn, sat_valid, rst_valid, nmi_ack, irq_ack;
    logic trap_open, single_chip, port_mode, fetch, sr_dn;
    logic rvalid, mode_hi, fetch_seen;
    logic [31:0] rd, sr_rdata, sat_result, program_status_word, tbase, pid;
    logic [25:0] next_pc, restore_pc, fetch_addr;
    logic [5:0] ev;
    cstr_sr_req_t sr_req;
    cstr_flags_t flags;
    int num_errors = 0;
    int checks = 0;
    cstr_core_model i_core (.clk_i(clk), .sr_req_o(sr_req), .flags_o(flags), .ev_o(ev),
        .next_pc_o(next_pc), .rdata_i(sr_rdata), .denied_i(sr_dn));
    cstr_regs #(.RESET_ENTRY(ENTRY)) i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SR_REQ_I(sr_req),
        .SR_RDATA_O(sr_rdata), .SR_RVALID_O(rvalid), .SR_DENIED_O(sr_dn), .FLAGS_I(flags),
        .SAT_RESULT_O(sat_result), .SAT_VALID_O(sat_valid), .TABLE_CALL_I(ev[0]),
        .EXC_TRAP_I(ev[1]), .DEBUG_TRAP_I(ev[2]), .ILLEGAL_OP_I(ev[3]), .DEBUG_RET_I(ev[4]),
        .EXCEPTION_I(ev[5]), .NEXT_PC_I(next_pc), .RESTORE_PC_O(restore_pc),
        .RESTORE_VALID_O(rst_valid), .NMI_REQ_I(nmi_req), .NMI_ACK_O(nmi_ack),
        .IRQ_REQ_I(irq_req), .IRQ_ACK_O(irq_ack), .PSW_O(program_status_word), .TABLE_BASE_O(tbase),
        .PROGRAM_ID_O(pid), .TRAP_OPEN_O(trap_open), .MODE_SELECT_LOW_PIN_I(1'b0),
        .MODE_SELECT_HIGH_PIN_I(mode_hi), .SINGLE_CHIP_O(single_chip), .PORT_MODE_O(port_mode),
        .FETCH_START_O(fetch), .FETCH_ADDR_O(fetch_addr));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        irq_req = 1'b0;
        nmi_req = 1'b0;
        mode_hi = 1'b0;
        repeat (4) @(posedge clk);
        chk("psw_reset", 32'h20, program_status_word);
        chk("port_mode", 32'h1, {31'h0, port_mode});
        rst_n <= 1'b1;
        for (int i = 0; i < 20 && fetch !== 1'b1; i++) @(posedge clk);
        chk("fetch_start", 32'h1, {31'h0, fetch});
        chk("fetch_addr", {6'h00, ENTRY}, {6'h00, fetch_addr});
        chk("single_chip", 32'h1, {31'h0, single_chip});
        for (int i = 0; i < 5; i++) begin
            i_core.sr_access(1'b1, 1'b0, NUMS[i], 32'hFFFF_FFFF, rd, dn);
            i_core.sr_access(1'b0, 1'b1, NUMS[i], 32'h0, rd, dn);
            chk("reg_mask", MASKS[i], rd);
            chk("reg_rvalid", 32'h1, {31'h0, rvalid});
            chk("reg_denied", {31'h0, MASKS[i] == 32'h0}, {31'h0, dn});
        end
        chk("table_base", 32'h03FF_FFFE, tbase);
        chk("program_id_full", 32'hFF, pid);
        i_core.init_id(rd, dn);
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_PROGRAM_IDENTIFIER, 32'h0, rd, dn);
        chk("program_id", 32'h0, rd);
        chk("program_id_out", 32'h0, pid);
        i_core.sr_access(1'b1, 1'b0, `CSTR_SR_PSW, 32'hFFFF_FF00, rd, dn);
        chk("psw_load", 32'h0, program_status_word);
        foreach (ROWS[i]) begin
            i_core.exec('{1'b1, ROWS[i].sat_op, ROWS[i].cy, ROWS[i].ov, ROWS[i].s, ROWS[i].z,
                ROWS[i].result});
            chk("psw_flags", {27'h0, ROWS[i].psw_low}, program_status_word);
            chk("sat_valid", {31'h0, ROWS[i].sat_op}, {31'h0, sat_valid});
            if (ROWS[i].sat_op) chk("sat_result", ROWS[i].sat_res, sat_result);
        end
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_TRAP_SAVED_PC, 32'h0, rd, dn);
        chk("closed_read", 32'h1, {31'h0, dn});
        i_core.event_pulse(0, 26'h0001234);
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_TABLE_CALL_SAVED_PC, 32'h0, rd, dn);
        chk("table_pc", 32'h1234, rd);
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_TABLE_CALL_SAVED_STATUS, 32'h0, rd, dn);
        chk("table_psw", 32'h1E, rd);
        i_core.event_pulse(1, 26'h0000040);
        i_core.event_pulse(3, 26'h0000040);
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_TRAP_SAVED_PC, 32'h0, rd, dn);
        chk("trap_pc", 32'h40, rd);
        i_core.event_pulse(2, 26'h3FF_FFFE);
        i_core.sr_access(1'b0, 1'b1, `CSTR_SR_TRAP_SAVED_PC, 32'h0, rd, dn);
        chk("dbg_pc", 32'h03FF_FFFE, rd);
        i_core.sr_access(1'b1, 1'b0, `CSTR_SR_TRAP_SAVED_STATUS, 32'hFFFF_FF0F, rd, dn);
        i_core.event_pulse(4, 26'h0);
        @(posedge clk);
        chk("restore_pc", 32'h03FF_FFFE, {6'h00, restore_pc});
        chk("restore_valid", 32'h1, {31'h0, rst_valid});
        chk("restore_psw", 32'h0F, program_status_word);
        irq_req <= 1'b1;
        @(posedge clk);
        chk("irq_ack", 32'h1, {31'h0, irq_ack});
        i_core.event_pulse(5, 26'h0);
        @(posedge clk);
        chk("irq_ack_ep", 32'h1, {31'h0, irq_ack});
        chk("ep_flag", 32'h1, {31'h0, program_status_word[6]});
        nmi_req <= 1'b1;
        @(posedge clk);
        chk("nmi_ack", 32'h1, {31'h0, nmi_ack});
        nmi_req <= 1'b0;
        @(posedge clk);
        chk("nmi_block", 32'h2, {30'h0, program_status_word[7], irq_ack});
        i_core.sr_access(1'b1, 1'b0, `CSTR_SR_PSW, 32'h0, rd, dn);
        chk("irq_unmasked", 32'h1, {31'h0, irq_ack});
        // Second edge sees the load request while the old word still enables interrupts
        fork
            i_core.sr_access(1'b1, 1'b0, `CSTR_SR_PSW, 32'h20, rd, dn);
            begin
                repeat (2) @(posedge clk);
                chk("irq_hold", 32'h0, {31'h0, irq_ack});
            end
        join
        chk("irq_masked", 32'h0, {31'h0, irq_ack});
        irq_req <= 1'b0;
        mode_hi <= 1'b1;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("psw_rereset", 32'h20, program_status_word);
        rst_n <= 1'b1;
        fetch_seen = 1'b0;
        repeat (10) begin
            @(posedge clk);
            fetch_seen = fetch_seen | fetch;
        end
        chk("no_fetch", 32'h0, {31'h0, fetch_seen});
        chk("not_single", 32'h0, {31'h0, single_chip});
        chk("port_mode_again", 32'h1, {31'h0, port_mode});
        results();
    end
endmodule : tb
